// ===== tws_defines.vh
// tws_defines.vh: register indices, field positions, reset values and codes
// assumes inclusion by the slave command/status block, its checker and the bench
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH

// register indices; the byte address is the index times four
`define TWS_IDX_MCTLA 8'h03
`define TWS_IDX_CTRLA 8'h09
`define TWS_IDX_CTRLB 8'h0a
`define TWS_IDX_STAT 8'h0b
`define TWS_IDX_DATA 8'h0d

// reset value and control a write mask
`define TWS_RST_BYTE 8'h00
`define TWS_CTRLA_MASK 8'he7

// master control field
`define TWS_MEN_BIT 0

// slave control a fields
`define TWS_BYTE_DONE_IRQ_EN_BIT 7
`define TWS_ADDR_STOP_IRQ_EN_BIT 6
`define TWS_STOP_FLAG_EN_BIT 5
`define TWS_SMART_MODE_EN_BIT 1

// slave control b fields
`define TWS_ACK_BIT 2
`define TWS_CMD_MSB 1
`define TWS_CMD_LSB 0

// slave commands
`define TWS_CMD_NO_OPERATION_CMD 2'h0
`define TWS_CMD_RSVD 2'h1
`define TWS_CMD_FINISH 2'h2
`define TWS_CMD_RESP 2'h3

// status bit positions
`define TWS_ST_DIF 7
`define TWS_ST_ADDR_STOP_FLAG 6
`define TWS_ST_CONTENTION_FLAG 3
`define TWS_ST_BUS_ERROR_FLAG 2

// bus protocol
`define TWS_BYTE_BITS 4'h8
`define TWS_RESP_OKAY 2'h0
`define TWS_RESP_SLVERR 2'h2

`endif

// ===== tws_slave_ctrl.v
// tws_slave_ctrl.v: two-wire slave command, status and byte engine
// assumes an axi4-lite master on aclk and open-drain scl/sda pads outside
//
// What this block does
// RULE_01: data register access in smart mode or execute command performs the selected acknowledge action
// RULE_02: ack select is a plain storage bit; 0 sends ack, 1 sends nack
// RULE_03: command field is a write strobe and always reads zero
// RULE_04: code 0 does nothing; code 1 is reserved and unused by software
// RULE_05: finish command: dir 0 acks then waits start; dir 1 only waits
// RULE_06: response after address: ack, then receive (dir 0) or data interrupt (dir 1)
// RULE_07: response after data: dir 0 ack then receive; dir 1 transmit a byte
// RULE_08: one write may set ack select and command; new ack value applies
// RULE_09: data access or valid command write clears the data and address/stop flags
// RULE_10: data flag sets on byte done, also at end of a collided byte
// RULE_11: data flag clears on write one, data access or valid command
// RULE_12: address/stop flag sets on address or enabled stop; clears like data flag
// RULE_13: clock hold flag is read-only, high while scl is stretched
// RULE_14: read-only received ack bit holds the last master ack, 1 is nack
// RULE_15: failure to drive high bit or nack sets collision and mutes sda
// RULE_16: collision on address nack leaves address/stop flag set
// RULE_17: collision clears on write one or any start condition
// RULE_18: misplaced start or stop sets bus error; write one clears it
// RULE_19: bus error detection works only with master enable set
// RULE_20: read-only direction bit holds r/w bit of last address
// RULE_21: no-action and reserved codes trigger nothing and clear nothing
// RULE_22: data irq only when data flag, its enable and global enable are one
// RULE_23: stop sets the address/stop flag only when stop flag enable is one
// RULE_24: address-or-stop bit reads 0 for stop and 1 for address
// RULE_25: with smart mode, data access continues; otherwise a command is needed
`timescale 1ns/10ps
`include "tws_defines.vh"

module tws_slave_ctrl (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [9:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read
  input wire [9:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // two-wire pins, open drain, enable low drives
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_n,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n,
  // interrupt requests
  input wire global_irq_en,
  output reg byte_done_irq,
  output reg addr_stop_irq
);

  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_ADDR = 8'h02;
  localparam [7:0] ST_AHOLD = 8'h04;
  localparam [7:0] ST_ACK = 8'h08;
  localparam [7:0] ST_RX = 8'h10;
  localparam [7:0] ST_DHOLD = 8'h20;
  localparam [7:0] ST_TX = 8'h40;
  localparam [7:0] ST_MACK = 8'h80;

  function hit;
    input [9:0] a;
    input [7:0] idx;
    begin
      hit = (a[9:2] == idx);
    end
  endfunction

  reg [7:0] state_reg;
  reg [7:0] ack_next_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ctrla_reg;
  reg men_reg;
  reg ack_act_reg;
  reg dif_reg;
  reg addr_stop_flag_reg;
  reg received_ack_bit_reg;
  reg contention_flag_reg;
  reg bus_error_flag_reg;
  reg dir_reg;
  reg ap_reg;
  reg mute_reg;
  reg after_addr_reg;
  reg nack_sent_reg;
  reg scl_s1_reg, scl_s2_reg, scl_d_reg;
  reg sda_s1_reg, sda_s2_reg, sda_d_reg;
  reg [7:0] rd_byte;
  reg rd_hit;

  // pin edges and bus conditions, read from the second sync stage onward
  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_det = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // axi side effects happen on the single cycle that ready is high
  wire wr_fire = awready;
  wire rd_fire = arready;
  wire wb = wstrb[0];
  wire [7:0] wd = wdata[7:0];
  wire wr_mctl = wr_fire & wb & hit(awaddr, `TWS_IDX_MCTLA);
  wire wr_ctrla = wr_fire & wb & hit(awaddr, `TWS_IDX_CTRLA);
  wire wr_ctrlb = wr_fire & wb & hit(awaddr, `TWS_IDX_CTRLB);
  wire wr_stat = wr_fire & wb & hit(awaddr, `TWS_IDX_STAT);
  wire wr_data = wr_fire & wb & hit(awaddr, `TWS_IDX_DATA);
  wire rd_data = rd_fire & hit(araddr, `TWS_IDX_DATA);
  wire wr_hit = hit(awaddr, `TWS_IDX_MCTLA) | hit(awaddr, `TWS_IDX_CTRLA) |
    hit(awaddr, `TWS_IDX_CTRLB) | hit(awaddr, `TWS_IDX_STAT) | hit(awaddr, `TWS_IDX_DATA);
  wire [1:0] cmd_code = wd[`TWS_CMD_MSB:`TWS_CMD_LSB];
  wire cmd_valid = wr_ctrlb & ((cmd_code == `TWS_CMD_FINISH) |
    (cmd_code == `TWS_CMD_RESP)); // see RULE_04 see RULE_21
  wire data_acc = wr_data | rd_data;
  wire clr_evt = cmd_valid | data_acc; // see RULE_09
  wire ack_eff = wr_ctrlb ? wd[`TWS_ACK_BIT] : ack_act_reg; // see RULE_08
  wire go = cmd_valid | (data_acc & ctrla_reg[`TWS_SMART_MODE_EN_BIT]); // see RULE_01 see RULE_25
  // a data access without a command counts as a response
  wire go_resp = ~cmd_valid | (cmd_code == `TWS_CMD_RESP);
  wire in_byte = (state_reg == ST_ADDR) | (state_reg == ST_RX) | (state_reg == ST_TX);
  wire bus_err = men_reg & (((start_det | stop_det) & in_byte & (bit_cnt_reg > 4'h1)) |
    (stop_det & (state_reg == ST_ADDR))); // see RULE_18 see RULE_19

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      ack_next_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= `TWS_RST_BYTE;
      ctrla_reg <= `TWS_RST_BYTE;
      men_reg <= 1'b0;
      ack_act_reg <= 1'b0;
      dif_reg <= 1'b0;
      addr_stop_flag_reg <= 1'b0;
      received_ack_bit_reg <= 1'b0;
      contention_flag_reg <= 1'b0;
      bus_error_flag_reg <= 1'b0;
      dir_reg <= 1'b0;
      ap_reg <= 1'b0;
      mute_reg <= 1'b0;
      after_addr_reg <= 1'b0;
      nack_sent_reg <= 1'b0;
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      byte_done_irq <= 1'b0;
      addr_stop_irq <= 1'b0;
    end else begin
      scl_s1_reg <= scl_i;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      byte_done_irq <= dif_reg & ctrla_reg[`TWS_BYTE_DONE_IRQ_EN_BIT] & global_irq_en; // see RULE_22
      addr_stop_irq <= addr_stop_flag_reg & ctrla_reg[`TWS_ADDR_STOP_IRQ_EN_BIT] & global_irq_en;
      if (wr_ctrla) begin
        ctrla_reg <= wd & `TWS_CTRLA_MASK;
      end
      if (wr_mctl) begin
        men_reg <= wd[`TWS_MEN_BIT];
      end
      if (wr_ctrlb) begin
        ack_act_reg <= wd[`TWS_ACK_BIT]; // see RULE_02
      end
      // clears come first so that a hardware set further down wins
      if (clr_evt | (wr_stat & wd[`TWS_ST_DIF])) begin
        dif_reg <= 1'b0; // see RULE_11
      end
      if (clr_evt | (wr_stat & wd[`TWS_ST_ADDR_STOP_FLAG])) begin
        addr_stop_flag_reg <= 1'b0; // see RULE_12
      end
      if (wr_stat & wd[`TWS_ST_CONTENTION_FLAG]) begin
        contention_flag_reg <= 1'b0; // see RULE_17
      end
      if (wr_stat & wd[`TWS_ST_BUS_ERROR_FLAG]) begin
        bus_error_flag_reg <= 1'b0; // see RULE_18
      end
      // the shift register only takes software data while the clock is held
      if (wr_data & ~scl_oe_n) begin
        shift_reg <= wd;
      end
      case (state_reg)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (scl_fall && bit_cnt_reg == `TWS_BYTE_BITS) begin
            bit_cnt_reg <= 4'h0;
            scl_oe_n <= 1'b0; // see RULE_13
            if (state_reg == ST_ADDR) begin
              addr_stop_flag_reg <= 1'b1; // see RULE_12
              ap_reg <= 1'b1; // see RULE_24
              dir_reg <= shift_reg[0]; // see RULE_20
              after_addr_reg <= 1'b1;
              state_reg <= ST_AHOLD;
            end else begin
              dif_reg <= 1'b1; // see RULE_10
              after_addr_reg <= 1'b0;
              state_reg <= ST_DHOLD;
            end
          end
        end
        ST_AHOLD, ST_DHOLD: begin
          if (go) begin
            scl_oe_n <= 1'b1; // see RULE_13
            bit_cnt_reg <= 4'h0;
            if (dir_reg && !go_resp) begin
              state_reg <= ST_IDLE; // see RULE_05
            end else if (dir_reg && !after_addr_reg) begin
              sda_oe_n <= shift_reg[7] | mute_reg; // see RULE_07
              state_reg <= ST_TX;
            end else begin
              sda_oe_n <= ack_eff | mute_reg; // see RULE_01 see RULE_08
              nack_sent_reg <= ack_eff;
              state_reg <= ST_ACK;
              if (!go_resp) begin
                ack_next_reg <= ST_IDLE; // see RULE_05
              end else if (dir_reg) begin
                ack_next_reg <= ST_DHOLD; // see RULE_06
              end else begin
                ack_next_reg <= ST_RX; // see RULE_06 see RULE_07
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            bit_cnt_reg <= 4'h1;
            // a nack that reads back low means someone else acked
            if (nack_sent_reg && !sda_s2_reg) begin
              contention_flag_reg <= 1'b1; // see RULE_15
              mute_reg <= 1'b1;
              if (after_addr_reg) begin
                addr_stop_flag_reg <= 1'b1; // see RULE_16
              end
            end
          end
          if (scl_fall && bit_cnt_reg == 4'h1) begin
            bit_cnt_reg <= 4'h0;
            sda_oe_n <= 1'b1;
            state_reg <= ack_next_reg;
            if (ack_next_reg == ST_DHOLD) begin
              dif_reg <= 1'b1; // see RULE_06
              scl_oe_n <= 1'b0;
              after_addr_reg <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (sda_oe_n && !sda_s2_reg && !mute_reg) begin
              contention_flag_reg <= 1'b1; // see RULE_15
              mute_reg <= 1'b1;
            end
          end
          if (scl_fall) begin
            if (bit_cnt_reg == `TWS_BYTE_BITS) begin
              bit_cnt_reg <= 4'h0;
              sda_oe_n <= 1'b1;
              state_reg <= ST_MACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_n <= shift_reg[6] | mute_reg; // see RULE_15
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            received_ack_bit_reg <= sda_s2_reg; // see RULE_14
            bit_cnt_reg <= 4'h1;
          end
          if (scl_fall && bit_cnt_reg == 4'h1) begin
            bit_cnt_reg <= 4'h0;
            dif_reg <= 1'b1; // see RULE_10
            after_addr_reg <= 1'b0;
            // a nack ends the read, so the clock is not held after it
            if (received_ack_bit_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              scl_oe_n <= 1'b0;
              state_reg <= ST_DHOLD;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // bus conditions override whatever the byte engine was doing
      if (start_det) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        mute_reg <= 1'b0;
        contention_flag_reg <= 1'b0; // see RULE_17
        sda_oe_n <= 1'b1;
        scl_oe_n <= 1'b1;
      end
      if (stop_det) begin
        state_reg <= ST_IDLE;
        bit_cnt_reg <= 4'h0;
        sda_oe_n <= 1'b1;
        scl_oe_n <= 1'b1;
        if (ctrla_reg[`TWS_STOP_FLAG_EN_BIT]) begin
          addr_stop_flag_reg <= 1'b1; // see RULE_23
          ap_reg <= 1'b0; // see RULE_24
        end
      end
      if (bus_err) begin
        bus_error_flag_reg <= 1'b1; // see RULE_18
      end
    end
  end

  // read mux; the command field is a strobe and reads as zero
  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (hit(araddr, `TWS_IDX_MCTLA)) begin
      rd_byte = {7'h00, men_reg};
    end else if (hit(araddr, `TWS_IDX_CTRLA)) begin
      rd_byte = ctrla_reg;
    end else if (hit(araddr, `TWS_IDX_CTRLB)) begin
      rd_byte = {5'h00, ack_act_reg, 2'h0}; // see RULE_03
    end else if (hit(araddr, `TWS_IDX_STAT)) begin
      rd_byte = {dif_reg, addr_stop_flag_reg, ~scl_oe_n, received_ack_bit_reg, contention_flag_reg, bus_error_flag_reg,
        dir_reg, ap_reg}; // see RULE_13
    end else if (hit(araddr, `TWS_IDX_DATA)) begin
      rd_byte = shift_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // axi4-lite slave: one write and one read outstanding at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `TWS_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `TWS_RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      awready <= awvalid & wvalid & ~bvalid & ~awready;
      wready <= awvalid & wvalid & ~bvalid & ~awready;
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      arready <= arvalid & ~rvalid & ~arready;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_byte};
        rresp <= rd_hit ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // tws_slave_ctrl

// ===== tws_slave_ctrl_assertions.sv
// tws_slave_ctrl_assertions.sv: checker for the slave command and status block
// assumes one aclk domain and whole-word register writes over axi4-lite
`timescale 1ns/10ps
`include "tws_defines.vh"
module tws_chk (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // register bus
  input logic [9:0] awaddr,
  input logic awready,
  input logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic [9:0] araddr,
  input logic arready,
  input logic rvalid,
  input logic [31:0] rdata,
  // pins and interrupts
  input logic scl_i,
  input logic sda_i,
  input logic scl_oe_n,
  input logic sda_oe_n,
  input logic global_irq_en,
  input logic byte_done_irq,
  input logic addr_stop_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] ri_reg, ca_reg;
  logic ack_reg, men_reg, contention_flag_reg, rv_reg, scl_reg, sda_reg;
  wire wr_go = awready && wready && wstrb[0];
  wire den = ca_reg[7];
  wire aen = ca_reg[6];
  // contention_flag is only visible through reads, so muting is checked from the read on
  always @(posedge aclk) begin
    if (!aresetn) begin
      ri_reg <= 8'h00;
      ca_reg <= 8'h00;
      {ack_reg, men_reg, contention_flag_reg, rv_reg} <= 4'h0;
      {scl_reg, sda_reg} <= 2'h3;
    end else begin
      rv_reg <= rvalid;
      scl_reg <= scl_i;
      sda_reg <= sda_i;
      if (arready) ri_reg <= araddr[9:2];
      if (wr_go && awaddr[9:2] == `TWS_IDX_CTRLB) ack_reg <= wdata[`TWS_ACK_BIT];
      if (wr_go && awaddr[9:2] == `TWS_IDX_CTRLA) ca_reg <= wdata[7:0];
      if (wr_go && awaddr[9:2] == `TWS_IDX_MCTLA && wdata[0]) men_reg <= 1'b1;
      if (scl_reg && scl_i && sda_reg && !sda_i) contention_flag_reg <= 1'b0;
      else if (rvalid && !rv_reg && ri_reg == `TWS_IDX_STAT && rdata[3]) contention_flag_reg <= 1'b1;
    end
  end
  sequence s_rd(logic [7:0] i);
    $rose(rvalid) && ri_reg == i;
  endsequence
  sequence s_stretch;
    $fell(scl_oe_n) && den && aen && global_irq_en;
  endsequence
  property p_cmd_zero;
    s_rd(`TWS_IDX_CTRLB) |-> rdata[1:0] == 2'h0;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("command field read nonzero");
  property p_ack_store;
    s_rd(`TWS_IDX_CTRLB) |-> rdata[2] == ack_reg;
  endproperty
  a_ack_store: assert property (p_ack_store)
    else $error("ack select read differs from last write");
  property p_hold_flag;
    s_rd(`TWS_IDX_STAT) |-> rdata[5] == !scl_oe_n;
  endproperty
  a_hold_flag: assert property (p_hold_flag)
    else $error("clock hold flag differs from scl stretch");
  property p_bus_error_flag_men;
    s_rd(`TWS_IDX_STAT) |-> !rdata[2] || men_reg;
  endproperty
  a_bus_error_flag_men: assert property (p_bus_error_flag_men)
    else $error("bus error without master enable");
  property p_dif_irq;
    byte_done_irq |-> $past(den) && $past(global_irq_en);
  endproperty
  a_dif_irq: assert property (p_dif_irq)
    else $error("data irq without its enables");
  property p_ap_irq;
    addr_stop_irq |-> $past(aen) && $past(global_irq_en);
  endproperty
  a_ap_irq: assert property (p_ap_irq)
    else $error("address irq without its enables");
  property p_stretch_irq;
    s_stretch |-> ##[1:3] (byte_done_irq || addr_stop_irq);
  endproperty
  a_stretch_irq: assert property (p_stretch_irq)
    else $error("scl stretched without a flag");
  property p_contention_flag_mute;
    contention_flag_reg |-> sda_oe_n;
  endproperty
  a_contention_flag_mute: assert property (p_contention_flag_mute)
    else $error("sda driven after collision");
endmodule // tws_chk
bind tws_slave_ctrl tws_chk u_chk (.aclk, .aresetn, .awaddr, .awready, .wready, .wdata,
  .wstrb, .araddr, .arready, .rvalid, .rdata, .scl_i, .sda_i, .scl_oe_n, .sda_oe_n,
  .global_irq_en, .byte_done_irq, .addr_stop_irq);

// ===== tws_i2c_master.sv
// tws_i2c_master.sv: behavioural two-wire bus master
// assumes open-drain lines with pull-ups resolved by the bench
`timescale 1ns/10ps
module tws_i2c_master (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // pulls, high pulls the line low
  output logic scl_low,
  output logic sda_low,
  // a stretch outlasted the limit
  output logic hang
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang = 1'b0;
  end
  // 180 ns per bit, 9 aclk, keeps the 4x clock margin
  task automatic bit_x(input logic b, output logic r);
    int n = 0;
    #40 sda_low = !b;
    #40 scl_low = 1'b0;
    while (scl !== 1'b1 && n < 3000) begin
      #20;
      n++;
    end
    if (n >= 3000) hang = 1'b1;
    #40 r = sda;
    #40 scl_low = 1'b1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #40 scl_low = 1'b0;
    #80 sda_low = 1'b1;
    #80 scl_low = 1'b1;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    #80 sda_low = 1'b0;
    #80;
  endtask
  task automatic byte_out(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
  endtask
  // f pulls sda low on the first bit to force a collision
  task automatic byte_in(input logic f, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_x(!(f && i == 7), d[i]);
  endtask
endmodule // tws_i2c_master

// ===== tws_tb.sv
// tws_tb.sv: self-checking bench for the slave command and status block
// assumes a bus master model on the pins and axi4-lite on aclk
`timescale 1ns/10ps
`include "tws_defines.vh"
module tb;
  localparam logic [9:0] MC = {`TWS_IDX_MCTLA, 2'b00};
  localparam logic [9:0] CA = {`TWS_IDX_CTRLA, 2'b00};
  localparam logic [9:0] CB = {`TWS_IDX_CTRLB, 2'b00};
  localparam logic [9:0] ST = {`TWS_IDX_STAT, 2'b00};
  localparam logic [9:0] DT = {`TWS_IDX_DATA, 2'b00};
  localparam logic [1:0] OK = `TWS_RESP_OKAY;
  localparam logic [1:0] ER = `TWS_RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, global_irq_en = 1'b1;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  wire awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n;
  wire byte_done_irq, addr_stop_irq, m_scl_low, m_sda_low, m_hang, scl_o, sda_o;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  // a short net delay keeps pin changes off the aclk sampling edge
  wire #2 scl = (scl_oe_n || scl_o) && !m_scl_low;
  wire #2 sda = (sda_oe_n || sda_o) && !m_sda_low;
  int err_total = 0, n_checks = 0, ack_m = 0, seed = 68;
  logic [7:0] rxq[$];
  always #10 aclk = !aclk;
  tws_slave_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n,
    .global_irq_en, .byte_done_irq, .addr_stop_irq);
  tws_i2c_master m (.scl, .sda, .scl_low(m_scl_low), .sda_low(m_sda_low), .hang(m_hang));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_v({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'h7};
    if (a == CB) ack_m = d[`TWS_ACK_BIT];
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        chk_v({30'h0, bresp}, {30'h0, er});
        n = 200;
      end
    end
    if (n == 100) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    d = 8'h00;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata[7:0];
        chk_v({30'h0, rresp}, {30'h0, er});
        n = 200;
      end
    end
    if (n == 100) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic st(input logic [7:0] k, input logic [7:0] e);
    logic [7:0] d;
    rd(ST, d, OK);
    chk_v(d & k, e);
  endtask
  always @(posedge m_hang) begin
    err_total++;
    finish_test();
  end
  initial begin
    logic [7:0] d;
    logic r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    st(8'hff, 8'h00);
    wr(CB, 8'h05, OK);
    rd(CB, d, OK);
    chk_v(d, {ack_m[0], 2'b00});
    rd(10'h3fc, d, ER);
    chk_v(d, 8'h00);
    wr(10'h3fc, 8'hff, ER);
    wr(MC, 8'h01, OK);
    wr(CA, 8'he0, OK);
    $display("test registers done");
    m.start();
    m.byte_out(8'ha4);
    repeat (8) @(posedge aclk);
    st(8'hef, 8'h61);
    chk_b(addr_stop_irq, 1'b1);
    fork
      wr(CB, 8'h03, OK);
      m.bit_x(1'b1, r);
    join
    chk_b(r, ack_m[0]);
    d = 8'($random(seed));
    rxq.push_back(d);
    m.byte_out(d);
    repeat (8) @(posedge aclk);
    for (int c = 0; c < 2; c++) wr(CB, c[7:0], OK);
    st(8'he0, 8'ha0);
    chk_b(byte_done_irq, 1'b1);
    global_irq_en <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_b(byte_done_irq, 1'b0);
    global_irq_en <= 1'b1;
    rd(DT, d, OK);
    chk_v(d, rxq.pop_front());
    st(8'hc0, 8'h00);
    fork
      wr(CB, 8'h06, OK);
      m.bit_x(1'b1, r);
    join
    chk_b(r, ack_m[0]);
    m.stop();
    repeat (8) @(posedge aclk);
    st(8'he1, 8'h40);
    wr(ST, 8'h40, OK);
    st(8'hc0, 8'h00);
    $display("test master write done");
    m.start();
    m.byte_out(8'ha5);
    repeat (8) @(posedge aclk);
    st(8'hef, 8'h63);
    fork
      wr(CB, 8'h03, OK);
      m.bit_x(1'b1, r);
    join
    chk_b(r, ack_m[0]);
    repeat (8) @(posedge aclk);
    st(8'he0, 8'ha0);
    wr(DT, 8'h80 | 8'($random(seed)), OK);
    st(8'h80, 8'h00);
    fork
      wr(CB, 8'h03, OK);
      m.byte_in(1'b1, d);
    join
    chk_v(d, 8'h7f);
    m.bit_x(1'b1, r);
    repeat (8) @(posedge aclk);
    st(8'h98, 8'h98);
    $display("test master read done");
    m.start();
    m.stop();
    repeat (8) @(posedge aclk);
    st(8'h0c, 8'h04);
    wr(ST, 8'h0c, OK);
    st(8'h0c, 8'h00);
    $display("test bus error done");
    wr(CA, 8'he2, OK);
    m.start();
    m.byte_out(8'ha4);
    repeat (8) @(posedge aclk);
    fork
      rd(DT, d, OK);
      m.bit_x(1'b1, r);
    join
    chk_v(d, 8'ha4);
    chk_b(r, ack_m[0]);
    m.stop();
    repeat (8) @(posedge aclk);
    st(8'he7, 8'h40);
    $display("test smart mode done");
    finish_test();
  end
endmodule // tb
